// [ppsw_pkg.sv]
// Purpose: shared constants and carriers for the process regulator with sleep supervisor
// Assumes: values are unsigned fixed point, 0.01 units for percent and Hz, kp and ki in 1/128 steps, kd in 1/8 steps; one tick per ms
// Notes  : all control settings are plain ports; no register bus
package ppsw_pkg;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_HZ      = 25_000_000;
  localparam int TICK_US     = 1000;
  localparam int TICK_CYC    = CLK_HZ / 1_000_000 * TICK_US;
  localparam int START_MAX_S = 2400;
  localparam int WAKE_MAX_DS = 6000;
  // ---------------------------------------------------------------
  // codes and limits
  // ---------------------------------------------------------------
  localparam logic [1:0]  EN_OFF     = 2'h0;
  localparam logic [1:0]  EN_AI1     = 2'h1;
  localparam logic [1:0]  EN_AI2     = 2'h2;
  localparam logic [2:0]  SRC_POT    = 3'h0;
  localparam logic [2:0]  SRC_AI1    = 3'h1;
  localparam logic [2:0]  SRC_AI2    = 3'h2;
  localparam logic [2:0]  SRC_KFREQ  = 3'h3;
  localparam logic [2:0]  SRC_COMM   = 3'h4;
  localparam logic [2:0]  SRC_UPDN   = 3'h5;
  localparam logic [2:0]  SRC_KSET   = 3'h7;
  localparam logic [15:0] KD_MAX     = 16'h00FF;
  localparam logic [15:0] HYST_RST   = 16'h0014;
  localparam logic [15:0] PCT_FULL   = 16'h2710;
  localparam logic [15:0] OUT_MAX    = 16'hFFFF;
  localparam int          GAIN_SHIFT = 7;
  localparam int          DIFF_SHIFT = 3;
  // ---------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pot;
    logic [15:0] ai1;
    logic [15:0] ai2;
    logic [15:0] kfreq;
    logic [15:0] comm;
    logic [15:0] updn;
  } ppsw_src_t;
  typedef struct packed {
    logic [15:0] kp;
    logic [15:0] ki;
    logic [15:0] kd;
  } ppsw_gain_t;
  typedef struct packed {
    logic [15:0] wake_bias;
    logic [15:0] wake_abs;
    logic [15:0] wake_pct;
    logic [15:0] wake_hyst;
    logic [15:0] sleep_freq;
    logic [15:0] sleep_pct;
  } ppsw_sleep_t;
  typedef enum logic [1:0] {
    PPSW_IDLE  = 2'b00,
    PPSW_HOLD  = 2'b01,
    PPSW_RUN   = 2'b10,
    PPSW_SLEEP = 2'b11
  } ppsw_state_t;
  // scale value by a 0.01 percent factor
  function automatic logic [15:0] ppsw_pct(input logic [15:0] v, input logic [15:0] p);
    logic [31:0] prod;
    prod = 32'(v) * 32'(p);
    return 16'(prod / 32'(PCT_FULL));
  endfunction
endpackage

// [ppsw_timer.sv]
// Purpose: duration timer that counts ticks while a condition holds
// Assumes: tick is a one cycle pulse from the same clock
// Notes  : limit of zero makes done follow cond at once
`timescale 1ns/1ps
module ppsw_timer
  import ppsw_pkg::*;
#(
  parameter int W = 24
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         reset_n,
  // control
  input  wire logic         tick,
  input  wire logic         cond,
  input  wire logic [W-1:0] limit,
  // status
  output logic              done
);
  logic [W-1:0] cnt_q;
  logic [W-1:0] cnt_d;
  // count while condition holds, clear when it drops
  assign cnt_d = !cond ? '0 : (tick && cnt_q < limit) ? cnt_q + W'(1) : cnt_q;
  assign done  = cond && (cnt_q >= limit);
  // counter register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // a dropped condition always clears the count
  timer_clear_a: assert property (@(posedge clk) disable iff (!reset_n)
    !cond |=> cnt_q == '0) else $error("timer not cleared");
endmodule

// [ppsw_core.sv]
// Purpose: process regulator with sleep and wake supervision, output frequency command
// Assumes: analog samples and settings are synchronous to clk; logic_inv comes from a pin
// Notes  : regulation updates once per tick; frequencies in 0.01 Hz
`timescale 1ns/1ps
module ppsw_core
  import ppsw_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // configuration
  input  wire logic [1:0]  pid_enable,
  input  wire logic [2:0]  src_select,
  input  wire logic        sign_invert,
  input  wire logic [11:0] start_delay_s,
  input  wire logic [12:0] wake_delay_ds,
  input  wire logic [12:0] sleep_delay_ds,
  input  wire ppsw_gain_t  gains,
  input  wire ppsw_sleep_t slp,
  // keypad setpoint
  input  wire logic        key_up,
  input  wire logic        key_down,
  input  wire logic        set_wr,
  input  wire logic [15:0] set_wdata,
  // process
  input  wire logic        run,
  input  wire logic        logic_inv,
  input  wire ppsw_src_t   src,
  // results
  output logic [15:0]      freq_cmd,
  output logic [15:0]      setpoint_q,
  output logic             asleep,
  output logic             src_conflict
);
  ppsw_state_t state_q, state_d;
  logic [15:0] tick_cnt_q;
  logic        tick;
  logic        inv_s1_q, inv_s2_q;
  logic [15:0] ksp_q;
  logic [15:0] out_q;
  logic [31:0] integ_q;
  logic signed [17:0] err_prev_q;
  // -------------------------------------------------------------
  // tick and pin synchroniser
  // -------------------------------------------------------------
  assign tick = (tick_cnt_q == 16'(TICK_CYCLES - 1));
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      tick_cnt_q <= 16'h0000;
      inv_s1_q   <= 1'b0;
      inv_s2_q   <= 1'b0;
    end else begin
      tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
      inv_s1_q   <= logic_inv;
      inv_s2_q   <= inv_s1_q;
    end
  end
  // -------------------------------------------------------------
  // source selection
  // -------------------------------------------------------------
  wire        pid_on   = (pid_enable == EN_AI1) || (pid_enable == EN_AI2);
  wire [15:0] feedback = (pid_enable == EN_AI2) ? src.ai2 : src.ai1;
  wire        conflict = pid_on && ((pid_enable == EN_AI1 && src_select == SRC_AI1) ||
                                    (pid_enable == EN_AI2 && src_select == SRC_AI2));
  logic [15:0] sel_val;
  always_comb begin
    unique case (src_select)
      SRC_POT:   sel_val = src.pot;
      SRC_AI1:   sel_val = src.ai1;
      SRC_AI2:   sel_val = src.ai2;
      SRC_KFREQ: sel_val = src.kfreq;
      SRC_COMM:  sel_val = src.comm;
      SRC_UPDN:  sel_val = src.updn;
      SRC_KSET:  sel_val = ksp_q;
      default:   sel_val = 16'h0000;
    endcase
  end
  // conflicting channel gives zero setpoint; same code feeds reference when off
  wire [15:0] setpoint = conflict ? 16'h0000 : sel_val;
  // keypad setpoint, a direct write wins over the arrows in the same cycle
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ksp_q <= 16'h0000;
    end else if (set_wr) begin
      ksp_q <= set_wdata;
    end else if (key_up && ksp_q != OUT_MAX) begin
      ksp_q <= ksp_q + 16'h0001;
    end else if (key_down && ksp_q != 16'h0000) begin
      ksp_q <= ksp_q - 16'h0001;
    end
  end
  // -------------------------------------------------------------
  // regulator arithmetic
  // -------------------------------------------------------------
  wire               invert  = sign_invert ^ inv_s2_q;
  wire signed [17:0] err_raw = $signed({2'b00, setpoint}) - $signed({2'b00, feedback});
  wire signed [17:0] err     = invert ? -err_raw : err_raw;
  wire [15:0]        kd_lim  = (gains.kd > KD_MAX) ? KD_MAX : gains.kd;
  wire signed [35:0] p_term  = err * $signed({2'b00, gains.kp});
  wire signed [35:0] i_step  = err * $signed({2'b00, gains.ki});
  wire signed [35:0] d_term  = (err - err_prev_q) * $signed({2'b00, kd_lim});
  wire signed [35:0] i_next  = $signed({4'h0, integ_q}) + (i_step >>> GAIN_SHIFT);
  wire signed [35:0] i_sat   = i_next < 0 ? 36'sd0 :
                               i_next > 36'sh0_FFFF_FFFF ? 36'sh0_FFFF_FFFF : i_next;
  wire signed [35:0] sum     = (p_term >>> GAIN_SHIFT) + (i_sat >>> GAIN_SHIFT)
                               + (d_term >>> DIFF_SHIFT);
  wire [15:0]        pid_out = sum < 0 ? 16'h0000 : sum > 36'sh0_0000_FFFF ? OUT_MAX
                               : sum[15:0];
  // -------------------------------------------------------------
  // timers and sleep supervision
  // -------------------------------------------------------------
  wire        sleep_off  = (sleep_delay_ds == 13'h0000);
  wire [15:0] pct_level  = ppsw_pct(setpoint, slp.sleep_pct);
  wire [15:0] wake_pctlv = ppsw_pct(setpoint, slp.wake_pct);
  wire        thr_sleep  = (slp.sleep_pct != 16'h0000) && (feedback > pct_level);
  wire        frq_sleep  = (slp.sleep_pct == 16'h0000) && (slp.sleep_freq != 16'h0000)
                           && (out_q <= slp.sleep_freq);
  wire [16:0] wake_freq  = {1'b0, slp.sleep_freq} + {1'b0, slp.wake_hyst};
  wire        dev_wake   = !err_raw[17] && (err_raw > $signed({2'b00, slp.wake_bias}));
  logic       wake_cond;
  // only the highest nonzero wake setting is used
  always_comb begin
    if (slp.wake_bias != 16'h0000) begin
      wake_cond = dev_wake;
    end else if (slp.wake_abs != 16'h0000) begin
      wake_cond = feedback > slp.wake_abs;
    end else if (slp.wake_pct != 16'h0000) begin
      wake_cond = feedback > wake_pctlv;
    end else begin
      wake_cond = {1'b0, sel_val} >= wake_freq;
    end
  end
  logic start_done, sleep_done, wake_done;
  ppsw_timer #(.W(24)) u_start (
    .clk(clk), .reset_n(reset_n), .tick(tick),
    .cond(state_q == PPSW_HOLD),
    .limit(24'(start_delay_s) * 24'd1000), .done(start_done));
  ppsw_timer #(.W(24)) u_sleep (
    .clk(clk), .reset_n(reset_n), .tick(tick),
    .cond(state_q == PPSW_RUN && !sleep_off && (thr_sleep || frq_sleep)),
    .limit(24'(sleep_delay_ds) * 24'd100), .done(sleep_done));
  ppsw_timer #(.W(24)) u_wake (
    .clk(clk), .reset_n(reset_n), .tick(tick),
    .cond(state_q == PPSW_SLEEP && wake_cond),
    .limit(24'(wake_delay_ds) * 24'd100), .done(wake_done));
  // state machine
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      PPSW_IDLE:  if (run && pid_on) state_d = PPSW_HOLD;
      PPSW_HOLD:  if (start_done) state_d = PPSW_RUN;
      PPSW_RUN:   if (sleep_done) state_d = PPSW_SLEEP;
      PPSW_SLEEP: if (wake_done || sleep_off) state_d = PPSW_RUN;
    endcase
    if (!run || !pid_on) state_d = PPSW_IDLE;
  end
  // -------------------------------------------------------------
  // regulator state and outputs
  // -------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_q    <= PPSW_IDLE;
      integ_q    <= 32'h0000_0000;
      err_prev_q <= 18'sh0_0000;
      out_q      <= 16'h0000;
    end else begin
      state_q <= state_d;
      // a fresh run starts its differential term from zero, not from a stale error
      if (!pid_on) begin
        out_q      <= sel_val;
        integ_q    <= 32'h0000_0000;
        err_prev_q <= 18'sh0_0000;
      end else if (state_q != PPSW_RUN) begin
        out_q      <= 16'h0000;
        integ_q    <= 32'h0000_0000;
        err_prev_q <= 18'sh0_0000;
      end else if (tick) begin
        integ_q    <= i_sat[31:0];
        err_prev_q <= err;
        out_q      <= pid_out;
      end
    end
  end
  assign freq_cmd     = out_q;
  assign setpoint_q   = ksp_q;
  assign asleep       = (state_q == PPSW_SLEEP);
  assign src_conflict = conflict;
  // -------------------------------------------------------------
  // checks
  // -------------------------------------------------------------
  bypass_pass_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pid_on |=> freq_cmd == $past(sel_val)) else $error("bypass wrong");
  conflict_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
    conflict |-> setpoint == 16'h0000) else $error("conflict not zeroed");
  hold_off_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == PPSW_HOLD |=> freq_cmd == 16'h0000) else $error("early regulation");
  sleep_dis_a: assert property (@(posedge clk) disable iff (!reset_n)
    sleep_off && state_q == PPSW_RUN |=> state_q != PPSW_SLEEP) else $error("slept");
  sign_pos_a: assert property (@(posedge clk) disable iff (!reset_n)
    !invert && feedback < setpoint |-> !err[17]) else $error("sign wrong");
  sign_neg_a: assert property (@(posedge clk) disable iff (!reset_n)
    invert && feedback < setpoint |-> err[17]) else $error("inverted sign wrong");
  kd_cap_a: assert property (@(posedge clk) disable iff (!reset_n)
    kd_lim <= KD_MAX) else $error("kd over limit");
  wake_only_a: assert property (@(posedge clk) disable iff (!reset_n)
    state_q == PPSW_SLEEP && state_d == PPSW_RUN |-> wake_done || sleep_off)
    else $error("woke without cause");
  key_set_a: assert property (@(posedge clk) disable iff (!reset_n)
    set_wr |=> setpoint_q == $past(set_wdata)) else $error("setpoint write lost");
  // bypass never sleeps; sleep keeps the regulator output parked at zero
  bypass_awake_a: assert property (@(posedge clk) disable iff (!reset_n)
    !pid_on |=> !asleep) else $error("asleep while bypassed");
  sleep_park_a: assert property (@(posedge clk) disable iff (!reset_n)
    pid_on && asleep |=> freq_cmd == 16'h0000) else $error("output while asleep");
  // main scenarios
  cov_sleep_c: cover property (@(posedge clk) state_q == PPSW_RUN ##1 state_q == PPSW_SLEEP);
  cov_wake_c:  cover property (@(posedge clk) state_q == PPSW_SLEEP ##1 state_q == PPSW_RUN);
  cov_start_c: cover property (@(posedge clk) state_q == PPSW_HOLD ##1 state_q == PPSW_RUN);
  cov_frq_c:   cover property (@(posedge clk) frq_sleep && sleep_done);
  cov_conf_c:  cover property (@(posedge clk) conflict && run);
endmodule

// [ppsw_plant.sv]
// Purpose: process sensor and motor stage model facing the regulator
// Assumes: the sensor level is set by the bench and sampled once per clock
// Notes  : the unselected analog input shows the inverse level, never a stale copy
`timescale 1ns/1ps
module ppsw_plant
  import ppsw_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // sensor and drive command
  input  wire logic [15:0] level,
  input  wire logic        ch,
  input  wire logic [15:0] freq_cmd,
  // sensor outputs and motor speed
  output logic      [15:0] ai1,
  output logic      [15:0] ai2,
  output logic      [15:0] motor_hz
);
  // sensor sampling; motor follows the command one clock late
  always_ff @(posedge clk) begin
    ai1      <= ch ? ~level : level;
    ai2      <= ch ? level : ~level;
    motor_hz <= reset_n ? freq_cmd : 16'h0000;
  end
endmodule

// [tb.sv]
// Purpose: self-checking bench for the process regulator with sleep supervisor
// Assumes: tick shortened to 4 clocks, so 0.1 s is 400 clocks and 1 s is 4000
// Notes  : gains kp 1.0 (0x80), ki 0, kd 0 make the command equal to the error
`timescale 1ns/1ps
module tb;
  import ppsw_pkg::*;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk, reset_n, sign_invert, key_up, key_down, set_wr, run, logic_inv, ch;
  logic        asleep, src_conflict;
  logic [1:0]  pid_enable;
  logic [2:0]  src_select;
  logic [11:0] start_delay_s;
  logic [12:0] wake_delay_ds, sleep_delay_ds;
  logic [15:0] set_wdata, level, ai1_w, ai2_w, freq_cmd, setpoint_q;
  ppsw_gain_t  gains;
  ppsw_sleep_t slp;
  ppsw_src_t   src_v, src_w;
  int          error_cnt, num_checks, cycle_cnt;
  // analog inputs come from the sensor model
  assign src_w = {src_v.pot, ai1_w, ai2_w, src_v.kfreq, src_v.comm, src_v.updn};
  ppsw_core #(.TICK_CYCLES(4)) DUT (.clk(clk), .reset_n(reset_n), .pid_enable(pid_enable),
    .src_select(src_select), .sign_invert(sign_invert), .start_delay_s(start_delay_s),
    .wake_delay_ds(wake_delay_ds), .sleep_delay_ds(sleep_delay_ds), .gains(gains), .slp(slp),
    .key_up(key_up), .key_down(key_down), .set_wr(set_wr), .set_wdata(set_wdata), .run(run),
    .logic_inv(logic_inv), .src(src_w), .freq_cmd(freq_cmd), .setpoint_q(setpoint_q),
    .asleep(asleep), .src_conflict(src_conflict));
  ppsw_plant plant (.clk(clk), .reset_n(reset_n), .level(level), .ch(ch),
    .freq_cmd(freq_cmd), .ai1(ai1_w), .ai2(ai2_w), .motor_hz());
  // ---------------------------------------------------------------
  // clock, timeout and helpers
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // cut a hang short
  always @(posedge clk) begin
    cycle_cnt++;
    if (cycle_cnt == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic chk1(input string nm, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %b seen %b", nm, exp, got);
    end
  endtask
  // stop, then restart regulation with a feedback and setpoint choice
  task automatic pid_go(input logic [1:0] en, input logic [2:0] sel);
    run = 1'b0;
    cyc(2);
    pid_enable = en;
    src_select = sel;
    run = 1'b1;
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_pass();
    logic [15:0] exp [7];
    exp = '{16'h0011, 16'h0022, 16'hFFDD, 16'h0033, 16'h0044, 16'h0055, 16'h0000};
    for (int c = 0; c < 7; c++) begin
      src_select = 3'(c);
      cyc(3);
      chk16("reference pass", exp[c], freq_cmd);
    end
    $display("pass through done");
  endtask
  task automatic t_keypad();
    key_up = 1'b1;
    cyc(5);
    key_up = 1'b0;
    key_down = 1'b1;
    cyc(2);
    key_down = 1'b0;
    cyc(1);
    chk16("keypad arrows", 16'h0003, setpoint_q);
    set_wr = 1'b1;
    set_wdata = 16'h03E8;
    cyc(1);
    set_wr = 1'b0;
    pid_go(EN_AI1, SRC_KSET);
    cyc(40);
    chk16("keypad setpoint", 16'h03E8, setpoint_q);
    chk16("keypad regulation", 16'h0258, freq_cmd);
    $display("keypad done");
  endtask
  task automatic t_conflict();
    pid_go(EN_AI1, SRC_AI1);
    cyc(1);
    chk1("conflict one", 1'b1, src_conflict);
    pid_go(EN_AI2, SRC_AI2);
    cyc(1);
    chk1("conflict two", 1'b1, src_conflict);
    ch = 1'b1;
    pid_go(EN_AI2, SRC_POT);
    cyc(40);
    chk1("no conflict", 1'b0, src_conflict);
    chk16("second input feedback", 16'h0258, freq_cmd);
    ch = 1'b0;
    $display("conflict done");
  endtask
  task automatic t_sign();
    pid_go(EN_AI1, SRC_POT);
    cyc(40);
    chk16("direct low feedback", 16'h0258, freq_cmd);
    sign_invert = 1'b1;
    cyc(12);
    chk16("inverted low feedback", 16'h0000, freq_cmd);
    level = 16'h0640;
    cyc(12);
    chk16("inverted high feedback", 16'h0258, freq_cmd);
    sign_invert = 1'b0;
    logic_inv = 1'b1;
    cyc(12);
    chk16("pin inverted", 16'h0258, freq_cmd);
    logic_inv = 1'b0;
    cyc(12);
    chk16("direct high feedback", 16'h0000, freq_cmd);
    level = 16'h0190;
    gains.ki = 16'h0080;
    cyc(40);
    chk1("integral grows", 1'b1, freq_cmd > 16'h0258);
    gains.ki = 16'h0000;
    $display("sign done");
  endtask
  task automatic t_start();
    start_delay_s = 12'h001;
    pid_go(EN_AI1, SRC_POT);
    cyc(3900);
    chk16("start hold", 16'h0000, freq_cmd);
    cyc(200);
    chk16("start release", 16'h0258, freq_cmd);
    start_delay_s = 12'h000;
    $display("start delay done");
  endtask
  task automatic t_sleep();
    level = 16'h04B0;
    slp.sleep_pct = PCT_FULL;
    pid_go(EN_AI1, SRC_POT);
    cyc(600);
    chk1("sleep disabled", 1'b0, asleep);
    sleep_delay_ds = 13'h0001;
    cyc(380);
    chk1("sleep early", 1'b0, asleep);
    cyc(60);
    chk1("sleep entered", 1'b1, asleep);
    slp.wake_bias = 16'h00C8;
    slp.wake_abs = 16'h0064;
    cyc(600);
    chk1("higher wake rules", 1'b1, asleep);
    level = 16'h01F4;
    cyc(300);
    level = 16'h04B0;
    cyc(20);
    level = 16'h01F4;
    cyc(380);
    chk1("wake timer restart", 1'b1, asleep);
    cyc(60);
    chk1("deviation wake", 1'b0, asleep);
    level = 16'h04B0;
    cyc(460);
    chk1("asleep again", 1'b1, asleep);
    slp.wake_bias = 16'h0000;
    cyc(430);
    chk1("feedback wake", 1'b0, asleep);
    $display("sleep done");
  endtask
  task automatic t_modes();
    slp.wake_abs = 16'h0000;
    slp.wake_pct = PCT_FULL;
    slp.sleep_freq = 16'h0064;
    level = 16'h03B6;
    pid_go(EN_AI1, SRC_POT);
    cyc(440);
    chk1("threshold mode outranks", 1'b0, asleep);
    slp.sleep_pct = 16'h0000;
    cyc(440);
    chk1("frequency sleep", 1'b1, asleep);
    cyc(440);
    chk1("percent wake outranks", 1'b1, asleep);
    level = 16'h04B0;
    cyc(440);
    chk1("percent wake", 1'b0, asleep);
    slp.wake_pct = 16'h0000;
    slp.sleep_freq = 16'h03E8;
    cyc(440);
    chk1("below wake frequency", 1'b1, asleep);
    slp.sleep_freq = 16'h03D4;
    cyc(440);
    chk1("frequency wake", 1'b0, asleep);
    $display("wake modes done");
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset_n, sign_invert, key_up, key_down, set_wr, run, logic_inv, ch} = 8'h00;
    {error_cnt, num_checks, cycle_cnt} = '0;
    pid_enable = EN_OFF;
    src_select = SRC_POT;
    start_delay_s = 12'h000;
    wake_delay_ds = 13'h0001;
    sleep_delay_ds = 13'h0000;
    set_wdata = 16'h0000;
    level = 16'h0022;
    gains = '{16'h0080, 16'h0000, 16'h0000};
    slp = '{16'h0000, 16'h0000, 16'h0000, HYST_RST, 16'h0000, 16'h0000};
    src_v = '{16'h0011, 16'h0000, 16'h0000, 16'h0033, 16'h0044, 16'h0055};
    cyc(20);
    reset_n = 1'b1;
    cyc(2);
    t_pass();
    src_v.pot = 16'h03E8;
    level = 16'h0190;
    t_keypad();
    t_conflict();
    t_sign();
    t_start();
    t_sleep();
    t_modes();
    end_of_test();
  end
endmodule
